//--- tb_vcx_exec.sv
/*
  self-checking bench for vcx_exec with the far-side model.
  assumes short frame and watchdog counts set by parameter.
*/
`timescale 1ns/1ps
`include "vcx_regs.vh"
module tb_vcx_exec;
  reg clk_sys = 1'b0, resetn = 1'b0, ins_valid = 1'b0, acc_sel = 1'b0;
  reg [3:0] ins_op = 4'h0, ins_field = 4'h0, ws_word = 4'h0;
  reg [15:0] in_primary = 16'h8421;
  reg [7:0] in_secondary = 8'h96, we;
  wire [7:0] rom_data, out_data, out_latch_we, ws_addr;
  wire [11:0] acc_a, acc_b, rom_addr, vec_x, vec_y, reset_pc;
  wire [3:0] ws_page;
  wire vec_done, ins_ready, negative_flag, right_shift_out_flag, rom_rd, vec_start, vec_busy, cpu_reset_req;
  reg [11:0] ea = 12'h000, eb = 12'h000;
  reg en = 1'b0, er = 1'b0, vs;
  integer miscompares = 0, n_checks = 0, nw = 0, n_rst = 0, i;
  always #25 clk_sys = ~clk_sys;
  vcx_exec #(.FRAME_CYC(200), .WD_CYC(250)) uut (.clk_sys(clk_sys), .resetn(resetn), .ins_valid(ins_valid),
    .ins_op(ins_op), .ins_field(ins_field), .acc_sel(acc_sel), .ws_word(ws_word), .in_primary(in_primary),
    .in_secondary(in_secondary), .rom_data(rom_data), .vec_done(vec_done), .ins_ready(ins_ready), .acc_a(acc_a),
    .acc_b(acc_b), .negative_flag(negative_flag), .right_shift_out_flag(right_shift_out_flag), .rom_addr(rom_addr),
    .rom_rd(rom_rd), .out_data(out_data), .out_latch_we(out_latch_we), .vec_x(vec_x), .vec_y(vec_y),
    .vec_start(vec_start), .vec_busy(vec_busy), .ws_page(ws_page), .ws_addr(ws_addr),
    .cpu_reset_req(cpu_reset_req), .reset_pc(reset_pc));
  vcx_far_model far (.clk_sys(clk_sys), .resetn(resetn), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .vec_start(vec_start), .rom_data(rom_data), .vec_done(vec_done));
  always @(posedge clk_sys)
    if (cpu_reset_req === 1'b1)
      n_rst <= n_rst + 1;
  task conclude;
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [11:0] a, input logic [11:0] e);
    n_checks = n_checks + 1;
    if (a !== e)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0t got %h want %h", $time, a, e);
    end
  endtask
  task run(input [3:0] op, input [3:0] f, input s, input c);
    @(posedge clk_sys);
    ins_valid <= 1'b1;
    ins_op    <= op;
    ins_field <= f;
    acc_sel   <= s;
    @(posedge clk_sys);
    ins_valid <= 1'b0;
    #1;
    we = out_latch_we;
    vs = vec_start;
    nw = 0;
    while (ins_ready !== 1'b1 && nw < 1000)
    begin
      @(posedge clk_sys);
      #1;
      nw = nw + 1;
    end
    chk(ins_ready, 1'b1);
    case (op)
      `VCX_OP_ASR: if (!s) {ea, er} = {ea[11], ea}; else eb = {eb[11], eb[11:1]};
      `VCX_OP_SHL1: if (!s) {en, ea} = {ea[10], ea[10:0], 1'b0}; else {en, eb} = {eb[10], eb[10:0], 1'b0};
      `VCX_OP_SHL2: {en, ea, eb} = {ea[10], ea[10:0], 1'b0, eb[10:0], 1'b0};
      `VCX_OP_LOOKUP: ea = {4'h0, ea[7:0] ^ 8'hc3};
      `VCX_OP_INPUT: if (!s) ea[0] = in_primary[f]; else eb = {11'h000, in_secondary[f[2:0]]};
      `VCX_OP_VNORM: while (ea[11] == ea[10] && eb[11] == eb[10] && (ea | eb) != 12'h000) {ea, eb} = {ea << 1, eb << 1};
      default: ;
    endcase
    if (c)
    begin
      chk(acc_a, ea);
      chk(acc_b, eb);
      chk({negative_flag, right_shift_out_flag}, {en, er});
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    resetn  <= 1'b1;
    ws_word <= 4'h7;
    run(`VCX_OP_LOOKUP, 4'h0, 1'b0, 1'b1);
    run(`VCX_OP_NOP, 4'h0, 1'b0, 1'b1);
    chk(nw[11:0] + 12'h001, 12'h008);
    repeat (4) run(`VCX_OP_SHL1, 4'h0, 1'b0, 1'b1);
    run(`VCX_OP_ASR, 4'h0, 1'b0, 1'b1);
    run(`VCX_OP_INPUT, 4'h0, 1'b0, 1'b1);
    run(`VCX_OP_ASR, 4'h0, 1'b0, 1'b1);
    run(`VCX_OP_INPUT, 4'h1, 1'b1, 1'b1);
    run(`VCX_OP_SHL2, 4'h0, 1'b0, 1'b1);
    run(`VCX_OP_ASR, 4'h0, 1'b1, 1'b1);
    run(`VCX_OP_SHL1, 4'h0, 1'b1, 1'b1);
    for (i = 0; i < 10; i = i + 1)
    begin
      run(`VCX_OP_OUTPUT, i[3:0], i[0], 1'b1);
      chk(we, (i < 8) ? (8'h01 << i) : 8'h00);
      if (i < 8) chk(out_data, i[0] ? eb[7:0] : ea[7:0]);
    end
    run(`VCX_OP_VSTART, 4'h0, 1'b0, 1'b1);
    chk(vec_x, ea);
    chk(vec_y, eb);
    run(`VCX_OP_VNORM, 4'h0, 1'b0, 1'b1);
    run(`VCX_OP_DRAW, 4'h0, 1'b0, 1'b1);
    chk({vs, vec_busy}, 2'b11);
    repeat (12) @(posedge clk_sys);
    #1;
    chk(vec_busy, 1'b0);
    run(`VCX_OP_SETPAGE, 4'h9, 1'b0, 1'b1);
    @(posedge clk_sys);
    #1;
    chk({ws_page, ws_addr}, 12'h997);
    run(`VCX_OP_FRAME, 4'h0, 1'b0, 1'b0);
    chk(nw > 0 && nw <= 200, 1'b1);
    run(`VCX_OP_WDCLR, 4'h0, 1'b0, 1'b1);
    repeat (300) @(posedge clk_sys);
    chk(n_rst[11:0], 12'h000);
    repeat (12) run(`VCX_OP_SHL2, 4'h0, 1'b0, 1'b1);
    run(`VCX_OP_FRAME, 4'h0, 1'b0, 1'b0);
    run(`VCX_OP_VNORM, 4'h0, 1'b0, 1'b0);
    @(posedge clk_sys);
    #1;
    chk(n_rst[11:0], 12'h001);
    conclude;
  end
  initial
  begin
    #1000000;
    miscompares = miscompares + 1;
    $display("MISMATCH %0t run did not complete", $time);
    conclude;
  end
endmodule
bind vcx_exec vcx_exec_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn), .ins_valid(ins_valid), .ins_op(ins_op),
  .ins_field(ins_field), .acc_sel(acc_sel), .ws_word(ws_word), .in_primary(in_primary),
  .in_secondary(in_secondary), .rom_data(rom_data), .vec_done(vec_done), .ins_ready(ins_ready), .acc_a(acc_a),
  .acc_b(acc_b), .negative_flag(negative_flag), .right_shift_out_flag(right_shift_out_flag), .rom_addr(rom_addr),
  .rom_rd(rom_rd), .out_data(out_data), .out_latch_we(out_latch_we), .vec_x(vec_x), .vec_y(vec_y),
  .vec_start(vec_start), .vec_busy(vec_busy), .ws_page(ws_page), .ws_addr(ws_addr),
  .cpu_reset_req(cpu_reset_req), .reset_pc(reset_pc));

//--- vcx_exec.v
/*
  execution logic for shifts, rom look-up, port transfers, vector commands, frame halt,
  watchdog, no-op timing and working-storage paging of a 12-bit dual-accumulator cpu.
  assumes instructions arrive as one-cycle ins_valid pulses, only while ins_ready is high,
  and that the rom answers rom_data one cycle after rom_addr/rom_rd.
*/
`timescale 1ns/1ps
`include "vcx_regs.vh"
module vcx_exec #(
  parameter FRAME_CYC = `VCX_FRAME_CYC,
  parameter WD_CYC    = `VCX_WD_CYC
) (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        ins_valid,
  input  wire [3:0]  ins_op,
  input  wire [3:0]  ins_field,
  input  wire        acc_sel,
  input  wire [3:0]  ws_word,
  input  wire [15:0] in_primary,
  input  wire [7:0]  in_secondary,
  input  wire [7:0]  rom_data,
  input  wire        vec_done,
  output reg         ins_ready,
  output reg  [11:0] acc_a,
  output reg  [11:0] acc_b,
  output reg         negative_flag,
  output reg         right_shift_out_flag,
  output reg  [11:0] rom_addr,
  output reg         rom_rd,
  output reg  [7:0]  out_data,
  output reg  [7:0]  out_latch_we,
  output reg  [11:0] vec_x,
  output reg  [11:0] vec_y,
  output reg         vec_start,
  output reg         vec_busy,
  output reg  [3:0]  ws_page,
  output reg  [7:0]  ws_addr,
  output reg         cpu_reset_req,
  output reg  [11:0] reset_pc
);
  localparam ST_IDLE   = 3'd0;
  localparam ST_LOOKUP = 3'd1;
  localparam ST_NOP    = 3'd2;
  localparam ST_NORM   = 3'd3;
  localparam ST_FRAME  = 3'd4;
  localparam ST_HANG   = 3'd5;

  // the taking edge and the releasing edge are both part of the 400 ns, hence the minus two
  localparam integer NOP_LOAD = `VCX_NOP_CYC - 2;

  reg  [2:0]  state;
  reg  [3:0]  wait_cnt;
  wire [31:0] nop_load_w = NOP_LOAD;
  reg         lk_sel;
  wire        frame_end;
  wire        wd_expire;
  wire        fire      = ins_valid & ins_ready;
  wire [11:0] acc_cur   = acc_sel ? acc_b : acc_a;
  wire [11:0] asr_out;
  wire        asr_lost;
  wire [11:0] shl_out;
  wire [11:0] dual_a;
  wire [11:0] dual_b;
  wire        norm_done;
  wire        norm_zero;

  // one-hot latch strobe from the 4-bit field; codes 8..15 select nothing
  function [7:0] latch_dec;
    input [3:0] f;
    begin
      latch_dec = f[3] ? 8'h00 : (8'h01 << f[2:0]);
    end
  endfunction

  vcx_shift_unit u_shift (
    .acc_in    (acc_cur),
    .acc_a     (acc_a),
    .acc_b     (acc_b),
    .asr_out   (asr_out),
    .asr_lost  (asr_lost),
    .shl_out   (shl_out),
    .dual_a    (dual_a),
    .dual_b    (dual_b),
    .norm_done (norm_done),
    .norm_zero (norm_zero)
  );

  vcx_frame_timer #(
    .FRAME_CYC (FRAME_CYC),
    .WD_CYC    (WD_CYC)
  ) u_timer (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .frame_req (fire && ins_op == `VCX_OP_FRAME),
    .wd_clear  (fire && ins_op == `VCX_OP_WDCLR),
    .frame_end (frame_end),
    .wd_expire (wd_expire)
  );

  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state                <= ST_IDLE;
      wait_cnt             <= 4'h0;
      lk_sel               <= 1'b0;
      ins_ready            <= 1'b1;
      acc_a                <= 12'h000;
      acc_b                <= 12'h000;
      negative_flag        <= 1'b0;
      right_shift_out_flag <= 1'b0;
      rom_addr             <= 12'h000;
      rom_rd               <= 1'b0;
      out_data             <= 8'h00;
      out_latch_we         <= 8'h00;
      vec_x                <= 12'h000;
      vec_y                <= 12'h000;
      vec_start            <= 1'b0;
      vec_busy             <= 1'b0;
      ws_page              <= 4'h0;
      ws_addr              <= 8'h00;
      cpu_reset_req        <= 1'b0;
      reset_pc             <= `VCX_RESET_PC;
    end
    else
    begin
      rom_rd        <= 1'b0;
      out_latch_we  <= 8'h00;
      vec_start     <= 1'b0;
      cpu_reset_req <= 1'b0;
      ws_addr       <= {ws_page, ws_word};
      // busy rises with the draw itself so a branch right after it already sees it
      if (vec_done && !vec_start)
        vec_busy <= 1'b0;
      if (wd_expire)
      begin
        // a missed watchdog clear restarts the program whatever is in flight
        state         <= ST_IDLE;
        ins_ready     <= 1'b1;
        cpu_reset_req <= 1'b1;
        reset_pc      <= `VCX_RESET_PC;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (fire)
            begin
              case (ins_op)
                `VCX_OP_NOP:
                begin
                  state     <= ST_NOP;
                  wait_cnt  <= nop_load_w[3:0];
                  ins_ready <= 1'b0;
                end
                `VCX_OP_ASR:
                begin
                  if (acc_sel)
                    acc_b <= asr_out;
                  else
                  begin
                    acc_a                <= asr_out;
                    right_shift_out_flag <= asr_lost;
                  end
                end
                `VCX_OP_SHL1:
                begin
                  if (acc_sel)
                    acc_b <= shl_out;
                  else
                    acc_a <= shl_out;
                  negative_flag <= shl_out[11];
                end
                `VCX_OP_SHL2:
                begin
                  acc_a         <= dual_a;
                  acc_b         <= dual_b;
                  negative_flag <= dual_a[11];
                end
                `VCX_OP_LOOKUP:
                begin
                  rom_addr  <= acc_cur;
                  rom_rd    <= 1'b1;
                  lk_sel    <= acc_sel;
                  state     <= ST_LOOKUP;
                  ins_ready <= 1'b0;
                end
                `VCX_OP_INPUT:
                begin
                  if (acc_sel)
                    acc_b <= {11'h000, in_secondary[ins_field[2:0]]};
                  else
                    acc_a <= {acc_a[11:1], in_primary[ins_field]};
                end
                `VCX_OP_OUTPUT:
                begin
                  out_data     <= acc_cur[7:0];
                  out_latch_we <= latch_dec(ins_field);
                end
                `VCX_OP_VSTART:
                begin
                  vec_x <= acc_a;
                  vec_y <= acc_b;
                end
                `VCX_OP_VNORM:
                begin
                  state     <= norm_zero ? ST_HANG : ST_NORM;
                  ins_ready <= 1'b0;
                end
                `VCX_OP_DRAW:
                begin
                  vec_start <= 1'b1;
                  vec_busy  <= 1'b1;
                end
                `VCX_OP_FRAME:
                begin
                  state     <= ST_FRAME;
                  ins_ready <= 1'b0;
                end
                `VCX_OP_SETPAGE:
                  ws_page <= ins_field;
                default:
                  state <= ST_IDLE;
              endcase
            end
          end
          ST_LOOKUP:
          begin
            // rom answers a cycle after the request, so the word is taken once rom_rd has dropped
            // rom is 8 bits wide; the word lands in the low byte
            if (!rom_rd)
            begin
              if (lk_sel)
                acc_b <= {4'h0, rom_data};
              else
                acc_a <= {4'h0, rom_data};
              state     <= ST_IDLE;
              ins_ready <= 1'b1;
            end
          end
          ST_NOP:
          begin
            if (wait_cnt == 4'h0)
            begin
              state     <= ST_IDLE;
              ins_ready <= 1'b1;
            end
            else
              wait_cnt <= wait_cnt - 4'h1;
          end
          ST_NORM:
          begin
            if (norm_done)
            begin
              state     <= ST_IDLE;
              ins_ready <= 1'b1;
            end
            else
            begin
              acc_a <= dual_a;
              acc_b <= dual_b;
            end
          end
          ST_FRAME:
          begin
            if (frame_end)
            begin
              state     <= ST_IDLE;
              ins_ready <= 1'b1;
            end
          end
          ST_HANG:
            state <= ST_HANG;
          default:
          begin
            state     <= ST_IDLE;
            ins_ready <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

//--- vcx_exec_monitor.sv
/*
  checker for vcx_exec: relations between its ports over time.
  assumes it is bound to vcx_exec and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "vcx_regs.vh"
module vcx_exec_monitor (
  input wire        clk_sys,
  input wire        resetn,
  input wire        ins_valid,
  input wire [3:0]  ins_op,
  input wire [3:0]  ins_field,
  input wire        acc_sel,
  input wire [3:0]  ws_word,
  input wire [15:0] in_primary,
  input wire [7:0]  in_secondary,
  input wire [7:0]  rom_data,
  input wire        vec_done,
  input wire        ins_ready,
  input wire [11:0] acc_a,
  input wire [11:0] acc_b,
  input wire        negative_flag,
  input wire        right_shift_out_flag,
  input wire [11:0] rom_addr,
  input wire        rom_rd,
  input wire [7:0]  out_data,
  input wire [7:0]  out_latch_we,
  input wire [11:0] vec_x,
  input wire [11:0] vec_y,
  input wire        vec_start,
  input wire        vec_busy,
  input wire [3:0]  ws_page,
  input wire [7:0]  ws_addr,
  input wire        cpu_reset_req,
  input wire [11:0] reset_pc
);
  wire tk = ins_valid && ins_ready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_lkp; tk && ins_op == `VCX_OP_LOOKUP && !acc_sel; endsequence
  sequence s_rom_ask; rom_rd && rom_addr == $past(acc_a); endsequence
  property p_asr; tk && ins_op == `VCX_OP_ASR && !acc_sel |=>
    acc_a == {$past(acc_a[11]), $past(acc_a[11:1])} && right_shift_out_flag == $past(acc_a[0]); endproperty
  a_asr: assert property (p_asr) else $error("primary arithmetic shift wrong");
  property p_asr_b; tk && ins_op == `VCX_OP_ASR && acc_sel |=>
    acc_b == {$past(acc_b[11]), $past(acc_b[11:1])} && $stable(right_shift_out_flag); endproperty
  a_asr_b: assert property (p_asr_b) else $error("secondary right shift wrong");
  property p_shl; tk && ins_op == `VCX_OP_SHL1 && !acc_sel |=>
    acc_a == {$past(acc_a[10:0]), 1'b0} && negative_flag == $past(acc_a[10]); endproperty
  a_shl: assert property (p_shl) else $error("single left shift wrong");
  property p_dual; tk && ins_op == `VCX_OP_SHL2 |=> acc_a == {$past(acc_a[10:0]), 1'b0} &&
    acc_b == {$past(acc_b[10:0]), 1'b0} && negative_flag == $past(acc_a[10]); endproperty
  a_dual: assert property (p_dual) else $error("dual left shift wrong");
  property p_lkp; s_lkp |=> s_rom_ask ##2 acc_a == {4'h0, $past(rom_data)} &&
    negative_flag == $past(negative_flag, 3); endproperty
  a_lkp: assert property (p_lkp) else $error("look-up result wrong");
  property p_inp; tk && ins_op == `VCX_OP_INPUT && !acc_sel |=>
    acc_a == {$past(acc_a[11:1]), $past(in_primary[ins_field])}; endproperty
  a_inp: assert property (p_inp) else $error("primary input wrong");
  property p_inp_b; tk && ins_op == `VCX_OP_INPUT && acc_sel |=>
    acc_b == {11'h000, $past(in_secondary[ins_field[2:0]])}; endproperty
  a_inp_b: assert property (p_inp_b) else $error("secondary input wrong");
  property p_out; tk && ins_op == `VCX_OP_OUTPUT && !ins_field[3] |=> out_latch_we == (8'h01 << $past(ins_field[2:0]))
    && out_data == ($past(acc_sel) ? $past(acc_b[7:0]) : $past(acc_a[7:0])); endproperty
  a_out: assert property (p_out) else $error("output latch write wrong");
  property p_vst; tk && ins_op == `VCX_OP_VSTART |=> vec_x == $past(acc_a) && vec_y == $past(acc_b); endproperty
  a_vst: assert property (p_vst) else $error("start point load wrong");
  property p_norm; tk && ins_op == `VCX_OP_VNORM && (acc_a != 12'h000 || acc_b != 12'h000) |->
    ##[1:13] (ins_ready && (acc_a[11] ^ acc_a[10] || acc_b[11] ^ acc_b[10])); endproperty
  a_norm: assert property (p_norm) else $error("normalize did not finish");
  property p_draw; tk && ins_op == `VCX_OP_DRAW |=> vec_start && vec_busy; endproperty
  a_draw: assert property (p_draw) else $error("draw not started");
  property p_busy; $past(resetn) && $fell(vec_busy) |-> $past(vec_done); endproperty
  a_busy: assert property (p_busy) else $error("busy dropped without done");
  property p_nop; tk && ins_op == `VCX_OP_NOP |=>
    (!ins_ready && $stable(acc_a) && $stable(acc_b))[*7] ##1 ins_ready; endproperty
  a_nop: assert property (p_nop) else $error("no-op timing wrong");
  property p_wd; cpu_reset_req |-> reset_pc == 12'h000; endproperty
  a_wd: assert property (p_wd) else $error("restart address not zero");
  property p_ws; $past(resetn) |-> ws_addr == {$past(ws_page), $past(ws_word)}; endproperty
  a_ws: assert property (p_ws) else $error("storage address wrong");
endmodule

//--- vcx_far_model.sv
/*
  far side of vcx_exec: program rom and vector generator.
  assumes rom_rd is a one-cycle pulse and vec_start a one-cycle pulse.
*/
`timescale 1ns/1ps
module vcx_far_model #(
  parameter [3:0] DRAW_CYC = 4'h6
) (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire [11:0] rom_addr,
  input  wire        rom_rd,
  input  wire        vec_start,
  output reg  [7:0]  rom_data = 8'h00,
  output reg         vec_done = 1'b0
);
  reg [3:0] cnt = 4'h0;
  // outside an answer the bus toggles so a stale word is never mistaken for data
  always @(posedge clk_sys)
    rom_data <= rom_rd ? (rom_addr[7:0] ^ 8'hc3) : ~rom_data;
  always @(posedge clk_sys)
  begin
    vec_done <= 1'b0;
    if (!resetn)
      cnt <= 4'h0;
    else if (vec_start)
      cnt <= DRAW_CYC;
    else if (cnt != 4'h0)
    begin
      cnt      <= cnt - 4'h1;
      vec_done <= (cnt == 4'h1);
    end
  end
endmodule

//--- vcx_frame_timer.v
/*
  frame pacing timer and cold-start watchdog.
  assumes frame_req and wd_clear are one-cycle pulses from the executor.
*/
`timescale 1ns/1ps
`include "vcx_regs.vh"
module vcx_frame_timer #(
  parameter FRAME_CYC = `VCX_FRAME_CYC,
  parameter WD_CYC    = `VCX_WD_CYC
) (
  input  wire clk_sys,
  input  wire resetn,
  input  wire frame_req,
  input  wire wd_clear,
  output reg  frame_end,
  output reg  wd_expire
);
  reg [19:0] frame_cnt;
  reg [16:0] wd_cnt;
  reg        wd_armed;
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      frame_cnt <= 20'h00000;
      frame_end <= 1'b0;
    end
    else if (frame_cnt == FRAME_CYC[19:0] - 20'h00001)
    begin
      frame_cnt <= 20'h00000;
      frame_end <= 1'b1;
    end
    else
    begin
      frame_cnt <= frame_cnt + 20'h00001;
      frame_end <= 1'b0;
    end
  end
  // watchdog runs from the frame instruction; a clear in the same cycle as expiry still wins
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wd_cnt    <= 17'h00000;
      wd_armed  <= 1'b0;
      wd_expire <= 1'b0;
    end
    else
    begin
      wd_expire <= 1'b0;
      if (wd_clear)
      begin
        wd_armed <= 1'b0;
        wd_cnt   <= 17'h00000;
      end
      else if (frame_req)
      begin
        wd_armed <= 1'b1;
        wd_cnt   <= 17'h00000;
      end
      else if (wd_armed)
      begin
        if (wd_cnt == WD_CYC[16:0] - 17'h00001)
        begin
          wd_expire <= 1'b1;
          wd_armed  <= 1'b0;
        end
        else
          wd_cnt <= wd_cnt + 17'h00001;
      end
    end
  end
endmodule

//--- vcx_regs.vh
/*
  constants for the vector cpu shift/io/frame execution block.
  assumes a 20 MHz clk_sys; times are given in their own unit and turned into cycles here.
*/
`ifndef VCX_REGS_VH
`define VCX_REGS_VH
`define VCX_CLK_MHZ        20
`define VCX_CLK_NS         50
// opcode selects (low 4 bits of the op field)
`define VCX_OP_NOP         4'h0
`define VCX_OP_ASR         4'h1
`define VCX_OP_SHL1        4'h2
`define VCX_OP_SHL2        4'h3
`define VCX_OP_LOOKUP      4'h4
`define VCX_OP_INPUT       4'h5
`define VCX_OP_OUTPUT      4'h6
`define VCX_OP_VSTART      4'h7
`define VCX_OP_VNORM       4'h8
`define VCX_OP_DRAW        4'h9
`define VCX_OP_FRAME       4'ha
`define VCX_OP_WDCLR       4'hb
`define VCX_OP_SETPAGE     4'hc
// times and derived counts
`define VCX_NOP_NS         400
`define VCX_NOP_CYC        ((`VCX_NOP_NS + `VCX_CLK_NS - 1) / `VCX_CLK_NS)
`define VCX_FRAME_US       26000
`define VCX_FRAME_CYC      (`VCX_FRAME_US * `VCX_CLK_MHZ)
`define VCX_WD_US          3000
`define VCX_WD_CYC         (`VCX_WD_US * `VCX_CLK_MHZ)
`define VCX_RESET_PC       12'h000
`endif

//--- vcx_shift_unit.v
/*
  combinational shift unit: arithmetic right, single left, dual left, one normalize step.
  assumes accumulators are 12 bits wide.
*/
`timescale 1ns/1ps
`include "vcx_regs.vh"
module vcx_shift_unit (
  input  wire [11:0] acc_in,
  input  wire [11:0] acc_a,
  input  wire [11:0] acc_b,
  output wire [11:0] asr_out,
  output wire        asr_lost,
  output wire [11:0] shl_out,
  output wire [11:0] dual_a,
  output wire [11:0] dual_b,
  output wire        norm_done,
  output wire        norm_zero
);
  assign asr_out   = {acc_in[11], acc_in[11:1]};
  assign asr_lost  = acc_in[0];
  assign shl_out   = {acc_in[10:0], 1'b0};
  assign dual_a    = {acc_a[10:0], 1'b0};
  assign dual_b    = {acc_b[10:0], 1'b0};
  // normalized once either delta has its top two bits differing
  assign norm_done = (acc_a[11] ^ acc_a[10]) | (acc_b[11] ^ acc_b[10]);
  assign norm_zero = (acc_a == 12'h000) && (acc_b == 12'h000);
endmodule
